/* File: shared/urbw_pkg.sv */
/*
 * Package for the receive wake-up block: register map, field positions,
 * reset values, receiver states and the APB carrier structs.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
package urbw_pkg;

    // =====================================================================
    // Register byte offsets
    localparam logic [7:0] RCV_STATUS_CTRL_OFS = 8'h00;
    localparam logic [7:0] RCV_BUFFER_OFS      = 8'h04;
    localparam logic [7:0] XMT_STATUS_CTRL_OFS = 8'h08;
    localparam logic [7:0] BAUD_CTRL_OFS       = 8'h0C;
    localparam logic [7:0] BAUD_DIV_HIGH_OFS   = 8'h10;
    localparam logic [7:0] BAUD_DIV_LOW_OFS    = 8'h14;
    localparam logic [7:0] IRQ_FLAGS_OFS       = 8'h18;
    localparam logic [7:0] IRQ_ENABLES_OFS     = 8'h1C;

    // =====================================================================
    // Field positions
    localparam int SERIAL_EN_POS   = 7;  // Receive status/control
    localparam int CONT_RCV_POS    = 4;
    localparam int FRAMING_ERR_POS = 2;
    localparam int OVERRUN_ERR_POS = 1;
    localparam int SYNC_MODE_POS   = 4;  // Transmit status/control
    localparam int RCV_IDLE_POS    = 6;  // Baud control
    localparam int DIV16_POS       = 3;
    localparam int WAKE_EN_POS     = 1;
    localparam int RCV_IRQ_POS     = 5;  // Interrupt flags and enables

    // =====================================================================
    // Reset values and sizes
    localparam logic [7:0] REG8_RESET  = 8'h00;
    localparam logic [7:0] XMT_RESET   = 8'h02;
    localparam int         DATA_BITS   = 8;
    localparam logic [2:0] LAST_BIT    = 3'h7;

    // =====================================================================
    // Receiver states
    typedef enum logic [1:0] {
        URBW_RX_IDLE,
        URBW_RX_START,
        URBW_RX_DATA,
        URBW_RX_STOP
    } urbw_rx_e;

    // =====================================================================
    // APB carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } urbw_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } urbw_apb_rsp_s;

endpackage

/* File: src/urbw_top.sv */
/*
 * Asynchronous serial receiver with auto-wake-up on a sync break,
 * reached over APB. Holds the receive buffer, error flags and the
 * wake-up edge logic.
 * Assumes core_clk_in keeps running; sleep_in marks the sleep state in
 * which the baud timing is frozen. The serial line and sleep_in are
 * asynchronous and are synchronised here.
 */
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module urbw_top
    import urbw_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic          core_clk_in,
    input  wire logic          rst_b_in,
    input  wire urbw_apb_req_s apb_req_in,
    output urbw_apb_rsp_s      apb_rsp_out,
    input  wire logic          serial_input_line_in,
    input  wire logic          sleep_in,
    output logic               rx_irq_out
);

    // =====================================================================
    // Elaboration checks
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;

    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_depth_check
        $error("BUF_DEPTH must be a power of two of at least 2");
    end

    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(BUF_DEPTH);

    // =====================================================================
    // State of the block
    typedef struct packed {
        logic                           rx_meta;
        logic                           rx_sync;
        logic                           rx_prev;
        logic                           sleep_meta;
        logic                           sleep_sync;
        logic [7:0]                     rcv_ctrl;
        logic [7:0]                     xmt_ctrl;
        logic [7:0]                     div_high;
        logic [7:0]                     div_low;
        logic [7:0]                     irq_en;
        logic                           div16;
        logic                           wake_enable_bit;
        logic                           wake_seen;
        logic                           wake_irq;
        logic                           overrun_error_flag;
        urbw_rx_e                       rx_state;
        logic [15:0]                    baud_cnt;
        logic [2:0]                     bit_idx;
        logic [7:0]                     shift;
        logic [BUF_DEPTH-1:0][8:0]      rx_buf;
        logic [PTR_W-1:0]               head;
        logic [CNT_W-1:0]               count;
        urbw_apb_rsp_s                  rsp;
        logic                           irq;
    } urbw_state_s;

    urbw_state_s state_reg;
    urbw_state_s state_next;

    // =====================================================================
    // Derived terms
    logic             fall_edge;
    logic             rise_edge;
    logic             rx_run;
    logic             wake_armed;
    logic             bus_done;
    logic             bus_rd_done;
    logic             bus_wr_done;
    logic             pop;
    logic             push;
    logic             push_framing_error_flag;
    logic             receive_irq_flag;
    logic [15:0]      bit_period;
    logic [PTR_W-1:0] tail;
    logic [8:0]       head_word;

    // Edge detection reads only the second synchroniser stage and its copy
    assign fall_edge  = state_reg.rx_prev & ~state_reg.rx_sync;
    assign rise_edge  = ~state_reg.rx_prev & state_reg.rx_sync;
    // Wake-up only acts in asynchronous mode with the port on
    assign wake_armed = state_reg.wake_enable_bit & ~state_reg.xmt_ctrl[SYNC_MODE_POS]
                        & state_reg.rcv_ctrl[SERIAL_EN_POS];
    // Normal reception needs the port on, continuous receive, async mode, not armed, not asleep
    assign rx_run     = state_reg.rcv_ctrl[SERIAL_EN_POS] & state_reg.rcv_ctrl[CONT_RCV_POS]
                        & ~state_reg.xmt_ctrl[SYNC_MODE_POS] & ~state_reg.wake_enable_bit
                        & ~state_reg.sleep_sync;
    assign bit_period = state_reg.div16 ? {state_reg.div_high, state_reg.div_low}
                                        : {8'h00, state_reg.div_low};
    assign bus_done    = apb_req_in.psel & apb_req_in.penable & state_reg.rsp.pready;
    assign bus_rd_done = bus_done & ~apb_req_in.pwrite;
    assign bus_wr_done = bus_done & apb_req_in.pwrite;
    assign pop         = bus_rd_done & (apb_req_in.paddr == RCV_BUFFER_OFS);
    assign tail        = PTR_W'(state_reg.head + state_reg.count[PTR_W-1:0]);
    assign head_word   = state_reg.rx_buf[state_reg.head];
    assign receive_irq_flag = (state_reg.count != '0) | state_reg.wake_irq;

    // =====================================================================
    // Next-state logic
    always_comb begin
        logic [31:0] rd_word;
        logic        rd_err;
        rd_word    = 32'h0000_0000;
        rd_err     = 1'b0;
        push       = 1'b0;
        push_framing_error_flag  = 1'b0;
        state_next = state_reg;

        // Two-stage synchronisers, then a delayed copy for edges
        state_next.rx_meta    = serial_input_line_in;
        state_next.rx_sync    = state_reg.rx_meta;
        state_next.rx_prev    = state_reg.rx_sync;
        state_next.sleep_meta = sleep_in;
        state_next.sleep_sync = state_reg.sleep_meta;

        // Receiver: idle when disabled, armed or overrun; frozen in sleep
        if (!rx_run && !state_reg.sleep_sync) begin
            state_next.rx_state = URBW_RX_IDLE;
        end else if (rx_run) begin
            unique case (state_reg.rx_state)
                URBW_RX_IDLE: begin
                    if (fall_edge && !state_reg.overrun_error_flag) begin
                        state_next.rx_state = URBW_RX_START;
                        state_next.baud_cnt = {1'b0, bit_period[15:1]};
                    end
                end
                URBW_RX_START: begin
                    if (state_reg.baud_cnt != 16'h0000) begin
                        state_next.baud_cnt = state_reg.baud_cnt - 16'h0001;
                    end else if (state_reg.rx_sync) begin
                        state_next.rx_state = URBW_RX_IDLE;      // False start
                    end else begin
                        state_next.rx_state = URBW_RX_DATA;
                        state_next.baud_cnt = bit_period;
                        state_next.bit_idx  = 3'h0;
                    end
                end
                URBW_RX_DATA: begin
                    if (state_reg.baud_cnt != 16'h0000) begin
                        state_next.baud_cnt = state_reg.baud_cnt - 16'h0001;
                    end else begin
                        state_next.shift    = {state_reg.rx_sync, state_reg.shift[7:1]};
                        state_next.baud_cnt = bit_period;
                        state_next.bit_idx  = state_reg.bit_idx + 3'h1;
                        if (state_reg.bit_idx == LAST_BIT) begin
                            state_next.rx_state = URBW_RX_STOP;
                        end
                    end
                end
                URBW_RX_STOP: begin
                    if (state_reg.baud_cnt != 16'h0000) begin
                        state_next.baud_cnt = state_reg.baud_cnt - 16'h0001;
                    end else begin
                        push                = 1'b1;
                        push_framing_error_flag           = ~state_reg.rx_sync;
                        state_next.rx_state = URBW_RX_IDLE;
                    end
                end
            endcase
        end

        // Receive buffer: a word that finds it full is dropped as overrun
        if (push && state_reg.count != FULL_COUNT) begin
            state_next.rx_buf[tail] = {push_framing_error_flag, state_reg.shift};
        end
        if (pop && state_reg.count != '0) begin
            state_next.head = state_reg.head + PTR_W'(1);
        end
        state_next.count = state_reg.count
                           + CNT_W'(push && state_reg.count != FULL_COUNT)
                           - CNT_W'(pop && state_reg.count != '0);
        // Overrun sets on a word that finds the buffer full; clearing continuous receive clears it
        state_next.overrun_error_flag = (state_reg.overrun_error_flag & state_reg.rcv_ctrl[CONT_RCV_POS])
                                        | (push && state_reg.count == FULL_COUNT);

        // Wake-up: falling edge raises the flag, next rising edge disarms
        if (wake_armed && !state_reg.wake_seen && fall_edge) begin
            state_next.wake_seen = 1'b1;
        end else if (wake_armed && state_reg.wake_seen && rise_edge) begin
            state_next.wake_seen       = 1'b0;
            state_next.wake_enable_bit = 1'b0;
        end
        // Set wins over the clear by a buffer read in the same cycle
        state_next.wake_irq = (state_reg.wake_irq & ~pop)
                              | (wake_armed & ~state_reg.wake_seen & fall_edge);

        // Register writes take effect at the completing edge
        if (bus_wr_done) begin
            unique case (apb_req_in.paddr)
                RCV_STATUS_CTRL_OFS: state_next.rcv_ctrl = apb_req_in.pwdata[7:0];
                XMT_STATUS_CTRL_OFS: state_next.xmt_ctrl = apb_req_in.pwdata[7:0];
                BAUD_CTRL_OFS: begin
                    state_next.div16           = apb_req_in.pwdata[DIV16_POS];
                    state_next.wake_enable_bit = apb_req_in.pwdata[WAKE_EN_POS];
                    state_next.wake_seen       = 1'b0;
                end
                BAUD_DIV_HIGH_OFS:   state_next.div_high = apb_req_in.pwdata[7:0];
                BAUD_DIV_LOW_OFS:    state_next.div_low  = apb_req_in.pwdata[7:0];
                IRQ_ENABLES_OFS:     state_next.irq_en   = apb_req_in.pwdata[7:0];
                default: ;
            endcase
        end

        // Read data mux
        unique case (apb_req_in.paddr)
            RCV_STATUS_CTRL_OFS: begin
                rd_word[7:0]            = state_reg.rcv_ctrl
                                          & ~(8'h01 << FRAMING_ERR_POS) & ~(8'h01 << OVERRUN_ERR_POS);
                rd_word[FRAMING_ERR_POS] = (state_reg.count != '0) & head_word[8];
                rd_word[OVERRUN_ERR_POS] = state_reg.overrun_error_flag;
            end
            RCV_BUFFER_OFS:      rd_word[7:0] = (state_reg.count != '0) ? head_word[7:0] : 8'h00;
            XMT_STATUS_CTRL_OFS: rd_word[7:0] = state_reg.xmt_ctrl;
            BAUD_CTRL_OFS: begin
                rd_word[RCV_IDLE_POS] = (state_reg.rx_state == URBW_RX_IDLE);
                rd_word[DIV16_POS]    = state_reg.div16;
                rd_word[WAKE_EN_POS]  = state_reg.wake_enable_bit;
            end
            BAUD_DIV_HIGH_OFS:   rd_word[7:0] = state_reg.div_high;
            BAUD_DIV_LOW_OFS:    rd_word[7:0] = state_reg.div_low;
            IRQ_FLAGS_OFS:       rd_word[RCV_IRQ_POS] = receive_irq_flag;
            IRQ_ENABLES_OFS:     rd_word[7:0] = state_reg.irq_en;
            default:             rd_err = 1'b1;
        endcase

        // APB answer: one wait state, then pready for one cycle
        if (bus_done) begin
            state_next.rsp = '0;
        end else if (apb_req_in.psel && apb_req_in.penable) begin
            state_next.rsp.pready  = 1'b1;
            state_next.rsp.pslverr = rd_err;
            state_next.rsp.prdata  = apb_req_in.pwrite ? 32'h0000_0000 : rd_word;
        end

        // Interrupt output follows the flag in step with the clock
        state_next.irq = receive_irq_flag & state_reg.irq_en[RCV_IRQ_POS];
    end

    // =====================================================================
    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg            <= '0;
            state_reg.rx_meta    <= 1'b1;
            state_reg.rx_sync    <= 1'b1;
            state_reg.rx_prev    <= 1'b1;
            state_reg.rcv_ctrl   <= REG8_RESET;
            state_reg.xmt_ctrl   <= XMT_RESET;
            state_reg.irq_en     <= REG8_RESET;
            state_reg.rx_state   <= URBW_RX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =====================================================================
    // Outputs straight from the state register
    assign apb_rsp_out = state_reg.rsp;
    assign rx_irq_out  = state_reg.irq;

endmodule

/* File: sim/urbw_serial_node.sv */
/*
 * Remote serial node model: drives the receive line, idle high, 8N1, LSB first.
 * Assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/100ps
module urbw_serial_node (
    input  wire logic clk_in,
    output logic      line_out
);
    // =====================================================================
    // Line control
    // Idle level is mark (high), the level of a released line
    initial line_out = 1'h1;

    // Holds the line at one level, used for breaks of all zeros
    task automatic drive(input logic v);
        line_out <= v;
    endtask

    // Sends one frame: start bit, eight data bits, stop bit
    task automatic send_byte(input logic [7:0] d, input int per);
        logic [9:0] fr;
        fr = {1'h1, d, 1'h0};
        for (int i = 0; i < 10; i++) begin
            line_out <= fr[i];
            repeat (per) @(posedge clk_in);
        end
    endtask
endmodule

/* File: sim/urbw_top_sva.sv */
/*
 * Checker for urbw_top: bus timing and decode, interrupt gating, wake-up.
 * Sees only the top ports; bound to every urbw_top instance.
 */
`timescale 1ns/100ps
module urbw_top_sva
    import urbw_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic          core_clk_in,
    input wire logic          rst_b_in,
    input wire urbw_apb_req_s apb_req_in,
    input wire urbw_apb_rsp_s apb_rsp_out,
    input wire logic          serial_input_line_in,
    input wire logic          sleep_in,
    input wire logic          rx_irq_out
);
    // =====================================================================
    // Shadows of the control bits that software wrote
    logic        line_q;
    logic        armed_sh;
    logic        fell_sh;
    logic        en_sh;
    logic        sync_sh;
    logic        ien_sh;
    wire  logic  wr_done = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && apb_rsp_out.pready;
    wire  logic [7:0]  wa = apb_req_in.paddr;
    wire  logic [31:0] wd = apb_req_in.pwdata;
    wire  logic  mapped = (wa[1:0] == 2'h0) && (wa <= IRQ_ENABLES_OFS);

    // Tracks arming, the falling edge and the rising edge that disarms
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_q <= 1'h1;
            armed_sh <= 1'h0;
            fell_sh <= 1'h0;
            en_sh <= 1'h0;
            sync_sh <= 1'h0;
            ien_sh <= 1'h0;
        end else begin
            line_q <= serial_input_line_in;
            en_sh <= (wr_done && wa == RCV_STATUS_CTRL_OFS) ? wd[SERIAL_EN_POS] : en_sh;
            sync_sh <= (wr_done && wa == XMT_STATUS_CTRL_OFS) ? wd[SYNC_MODE_POS] : sync_sh;
            ien_sh <= (wr_done && wa == IRQ_ENABLES_OFS) ? wd[RCV_IRQ_POS] : ien_sh;
            if (wr_done && wa == BAUD_CTRL_OFS) begin
                armed_sh <= wd[WAKE_EN_POS];
                fell_sh <= 1'h0;
            end else if (fell_sh && serial_input_line_in && !line_q) begin
                armed_sh <= 1'h0;
                fell_sh <= 1'h0;
            end else if (armed_sh && !serial_input_line_in && line_q) begin
                fell_sh <= 1'h1;
            end
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    // =====================================================================
    // Assertions
    a_reset_quiet: assert property (disable iff (1'h0) !rst_b_in |-> !rx_irq_out && !apb_rsp_out.pready)
        else $error("outputs active during reset");
    a_pready_single: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready)
        else $error("pready held longer than one cycle");
    a_ready_latency: assert property (apb_req_in.psel && !apb_req_in.penable |=> !apb_rsp_out.pready ##1 apb_rsp_out.pready)
        else $error("pready not two cycles after setup");
    a_slverr_map: assert property (apb_rsp_out.pready |-> apb_rsp_out.pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_rdata_zero: assert property (apb_rsp_out.pready && (apb_req_in.pwrite || !mapped) |-> apb_rsp_out.prdata == 32'h0)
        else $error("nonzero read data on write or unmapped access");
    a_irq_enable: assert property (rx_irq_out |-> $past(ien_sh))
        else $error("receive interrupt without its enable");
    a_wake_irq: assert property (
        armed_sh && !fell_sh && en_sh && !sync_sh && ien_sh && $fell(serial_input_line_in)
        |-> ##[2:8] rx_irq_out)
        else $error("no receive interrupt after wake edge");
    a_sync_no_wake: assert property (
        armed_sh && sync_sh && !rx_irq_out && $fell(serial_input_line_in)
        |=> !rx_irq_out [*8])
        else $error("wake interrupt in synchronous mode");
    a_armed_quiet: assert property (
        armed_sh && !fell_sh && ien_sh && $past(ien_sh, 2) && serial_input_line_in [*6]
        |-> !$rose(rx_irq_out))
        else $error("interrupt while armed with idle line");

    // Main scenarios reached
    c_wake_edge: cover property (armed_sh && $fell(serial_input_line_in));
    c_bus_error: cover property (apb_rsp_out.pready && apb_rsp_out.pslverr);
    c_irq_asleep: cover property ($rose(rx_irq_out) && sleep_in);
endmodule

bind urbw_top urbw_top_sva #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .serial_input_line_in(serial_input_line_in),
    .sleep_in(sleep_in), .rx_irq_out(rx_irq_out));

/* File: sim/urbw_top_tb.sv */
/*
 * Testbench for urbw_top: register reset values, bus errors, reception,
 * overrun and wake-up on a break. Assumes the node model and the checker bind.
 */
`timescale 1ns/100ps
module urbw_top_tb
    import urbw_pkg::*;
;
    localparam int PER = 8;  // Bit period from divisor low byte 7
    logic          core_clk;
    logic          rst_b;
    logic          sleep;
    logic          irq;
    logic          line;
    urbw_apb_req_s req;
    urbw_apb_rsp_s rsp;
    int            error_cnt;
    int            total_checks;
    int            cycles;
    logic [31:0]   seed;
    logic [7:0]    data [3];

    always #25 core_clk = ~core_clk;

    urbw_top #(.BUF_DEPTH(2)) dut_u (.core_clk_in(core_clk), .rst_b_in(rst_b), .apb_req_in(req),
        .apb_rsp_out(rsp), .serial_input_line_in(line), .sleep_in(sleep), .rx_irq_out(irq));
    urbw_serial_node node_u (.clk_in(core_clk), .line_out(line));

    // =====================================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] exp_reset(input logic [7:0] a);
        return (a == XMT_STATUS_CTRL_OFS) ? {24'h0, XMT_RESET} : {24'h0, REG8_RESET};
    endfunction

    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // One APB transfer; checks ready, error and read data at the completing edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex,
                        input logic ee);
        int n;
        n = 0;
        req <= '{1'h1, 1'h0, wr, a, wd};
        @(posedge core_clk);
        req.penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp.pready !== 1'h1 && n < 20);
        chk($sformatf("ready and error at %h", a), {30'h0, 1'h1, ee}, {30'h0, rsp.pready, rsp.pslverr});
        chk($sformatf("data at %h", a), ex, rsp.prdata);
        req <= '0;
        @(posedge core_clk);
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk("rx_irq_out", {31'h0, v}, {31'h0, irq});
    endtask

    // Cuts a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            finish_test();
        end
    end

    // =====================================================================
    // Main sequence
    initial begin
        core_clk = 1'h0;
        rst_b = 1'h0;
        sleep = 1'h0;
        req = '0;
        seed = 32'h7510C55B;
        error_cnt = 0;
        total_checks = 0;
        cycles = 0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        // Reset values, then unmapped and misaligned accesses
        for (int i = 0; i < 8; i++) begin
            if (i != 3) xfer(1'h0, 8'(i * 4), '0, exp_reset(8'(i * 4)), 1'h0);
        end
        xfer(1'h1, 8'h20, 32'hFF, '0, 1'h1);
        xfer(1'h0, 8'h22, '0, '0, 1'h1);
        // Port on, continuous receive, bit period PER, receive interrupt enabled
        xfer(1'h1, RCV_STATUS_CTRL_OFS, 32'h90, '0, 1'h0);
        xfer(1'h1, BAUD_DIV_LOW_OFS, 32'(PER - 1), '0, 1'h0);
        xfer(1'h1, IRQ_ENABLES_OFS, 32'h20, '0, 1'h0);
        // Three words unread: the third is dropped and overrun is set
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            data[i] = (i == 0) ? 8'hFF : seed[7:0];
            node_u.send_byte(data[i], PER);
        end
        repeat (PER) @(posedge core_clk);
        chk("rx_irq_out", 32'h1, {31'h0, irq});
        xfer(1'h0, RCV_STATUS_CTRL_OFS, '0, 32'h92, 1'h0);
        xfer(1'h0, RCV_BUFFER_OFS, '0, {24'h0, data[0]}, 1'h0);
        xfer(1'h0, RCV_BUFFER_OFS, '0, {24'h0, data[1]}, 1'h0);
        xfer(1'h0, IRQ_FLAGS_OFS, '0, '0, 1'h0);
        xfer(1'h1, RCV_STATUS_CTRL_OFS, 32'h80, '0, 1'h0);
        xfer(1'h1, RCV_STATUS_CTRL_OFS, 32'h90, '0, 1'h0);
        // Synchronous mode: an armed falling edge raises nothing
        xfer(1'h1, XMT_STATUS_CTRL_OFS, 32'h12, '0, 1'h0);
        xfer(1'h1, BAUD_CTRL_OFS, 32'h02, '0, 1'h0);
        node_u.drive(1'h0);
        repeat (10) @(posedge core_clk);
        xfer(1'h0, IRQ_FLAGS_OFS, '0, '0, 1'h0);
        node_u.drive(1'h1);
        xfer(1'h1, BAUD_CTRL_OFS, '0, '0, 1'h0);
        xfer(1'h1, XMT_STATUS_CTRL_OFS, 32'h02, '0, 1'h0);
        // Full break while asleep, then a break that rises early
        for (int k = 0; k < 2; k++) begin
            xfer(1'h0, BAUD_CTRL_OFS, '0, 32'h40, 1'h0);
            xfer(1'h1, BAUD_CTRL_OFS, 32'h02, '0, 1'h0);
            sleep <= 1'h1;
            node_u.drive(1'h0);
            wait_irq(1'h1);
            xfer(1'h0, BAUD_CTRL_OFS, '0, 32'h42, 1'h0);
            repeat ((k == 0) ? 12 * PER : PER) @(posedge core_clk);
            node_u.drive(1'h1);
            repeat (2 * PER) @(posedge core_clk);
            xfer(1'h0, BAUD_CTRL_OFS, '0, 32'h40, 1'h0);
            xfer(1'h0, RCV_BUFFER_OFS, '0, '0, 1'h0);
            xfer(1'h0, IRQ_FLAGS_OFS, '0, '0, 1'h0);
            sleep <= 1'h0;
            repeat (4) @(posedge core_clk);
            seed = xs(seed);
            node_u.send_byte(seed[7:0], PER);
            wait_irq(1'h1);
            // Data judged by its value, not by the wake bit or the flag
            xfer(1'h0, RCV_BUFFER_OFS, '0, {24'h0, seed[7:0]}, 1'h0);
        end
        finish_test();
    end
endmodule
